// ==== hw/aiox_port.v ====
// Host controller for the asynchronous I/O expansion port
//
// Operation
// - Select only for accesses inside port window
// - Acknowledge line chosen sets port width
// - Missing acknowledge ends cycle with bus error
// - Read: select low with direction high
// - Write: select low with direction low
// - Latch read data, then negate select
// - Write data stable before and during select
// - Peripheral MSB on bit 31, top lanes
// - Only naturally aligned transfers are issued
// - No transfer narrower than peripheral width
// - Wider transfers split into back-to-back cycles
// - 4096-byte window, ten address lines driven
// - Select and acknowledges are active low
// - Interrupt inputs map to levels 3, 4
`timescale 1ns/1ps
`include "aiox_port_defs.vh"
module aiox_port #(
  parameter [31:0] WIN_BASE = `AIOX_WIN_BASE,
  parameter [`AIOX_CNT_W-1:0] TMO_OLD_CYC = `AIOX_TMO_OLD_CYC,
  parameter [`AIOX_CNT_W-1:0] TMO_NEW_CYC = `AIOX_TMO_NEW_CYC
) (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst_n,
  input wire ce,
  // Static configuration
  input wire cfgLateBoard,
  input wire cfgWordDevice,
  // Processor request
  input wire reqValid,
  input wire reqWrite,
  input wire [31:0] reqAddr,
  input wire [1:0] reqSize,
  input wire [31:0] reqWrData,
  output reg reqReady_q,
  // Processor answer
  output reg rspValid_q,
  output reg rspBusErr_q,
  output reg rspFault_q,
  output reg rspWordAck_q,
  output reg [31:0] rspRdData_q,
  // Expansion port pins
  output reg [`AIOX_ADDR_LINES-1:0] portAddr_q,
  output reg [1:0] addrSpare_q,
  output reg rdWr_q,
  output reg selN_q,
  input wire byte_ack_n,
  input wire word_ack_n,
  input wire [15:0] dataIn,
  output reg [15:0] dataOut_q,
  output reg dataOe_q,
  // Peripheral interrupts and processor levels
  input wire irq3N,
  input wire irq4N,
  output reg irqLevel3_q,
  output reg irqLevel4_q
);

  // One-hot states
  localparam [5:0] ST_IDLE = 6'h01; // Waiting for a request
  localparam [5:0] ST_SETUP = 6'h02; // Address and data lead before select
  localparam [5:0] ST_SEL = 6'h04; // Select low, waiting for acknowledge
  localparam [5:0] ST_HOLD = 6'h08; // Select held after acknowledge
  localparam [5:0] ST_AHOLD = 6'h10; // Address held after select rises
  localparam [5:0] ST_GAP = 6'h20; // Idle gap and acknowledge release

  // Cycle counts at counter width
  localparam [`AIOX_CNT_W-1:0] ADDR_LEAD = `AIOX_ADDR_LEAD_CYC;
  localparam [`AIOX_CNT_W-1:0] DATA_LEAD = `AIOX_DATA_LEAD_CYC;
  localparam [`AIOX_CNT_W-1:0] SETUP_CYC = (ADDR_LEAD > DATA_LEAD) ? ADDR_LEAD : DATA_LEAD;
  localparam [`AIOX_CNT_W-1:0] HOLD_CYC = `AIOX_SEL_HOLD_CYC;
  localparam [`AIOX_CNT_W-1:0] AHOLD_CYC = `AIOX_ADDR_HOLD_CYC;
  localparam [`AIOX_CNT_W-1:0] GAP_CYC = `AIOX_GAP_CYC;
  localparam [`AIOX_CNT_W-1:0] CNT_ONE = 1;

  reg [5:0] state_q; // Controller state
  reg [`AIOX_CNT_W-1:0] cnt_q; // Delay and timeout counter
  reg [2:0] remBytes_q; // Bytes still to move in this transfer
  reg [31:0] curAddr_q; // Address of the current bus cycle
  reg [31:0] wrBuf_q; // Write bytes, next one at the top
  reg [31:0] rdBuf_q; // Read bytes, gathered from the bottom
  reg errSeen_q; // Bus error seen in this transfer
  reg narrowSeen_q; // Byte left for a word-wide device

  wire [`AIOX_SY_W-1:0] syncIn; // Raw levels into the synchroniser
  wire [`AIOX_SY_W-1:0] syncOut; // Synchronised levels
  wire byteAck; // Synchronised byte acknowledge, active high
  wire wordAck; // Synchronised word acknowledge, active high
  wire anyAck; // Either acknowledge present
  wire inWindow; // Request falls inside the port window
  wire aligned; // Request is naturally aligned
  wire narrow; // Byte request aimed at a word-wide device
  wire [`AIOX_CNT_W-1:0] tmoCyc; // Timeout chosen for this board
  wire [2:0] reqBytes; // Byte count of the request
  wire [2:0] stepBytes; // Bytes moved by the cycle just acknowledged

  // All four asynchronous inputs idle high; acknowledges and interrupts alike
  assign syncIn = {irq4N, irq3N, word_ack_n, byte_ack_n};

  aiox_sync #(
    .W(`AIOX_SY_W),
    .RESET_VAL({`AIOX_SY_W{1'b1}})
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .asyncIn(syncIn),
    .syncOut(syncOut)
  );

  // Active-low pins turned into active-high events
  assign byteAck = ~syncOut[`AIOX_SY_BACK];
  assign wordAck = ~syncOut[`AIOX_SY_WACK];
  assign anyAck = byteAck | wordAck;

  // Window decode on the bits above the 4096-byte window
  assign inWindow = (reqAddr[31:`AIOX_WIN_LSB] == WIN_BASE[31:`AIOX_WIN_LSB]);

  // Natural alignment, no size lines reach the peripheral
  assign aligned = (reqSize == `AIOX_SIZE_BYTE) ||
                   ((reqSize == `AIOX_SIZE_WORD) && (reqAddr[0] == 1'b0)) ||
                   ((reqSize == `AIOX_SIZE_LONG) && (reqAddr[1:0] == 2'h0));

  // A byte cannot be moved to a word-wide device
  assign narrow = cfgWordDevice && (reqSize == `AIOX_SIZE_BYTE);

  assign tmoCyc = cfgLateBoard ? TMO_NEW_CYC : TMO_OLD_CYC;

  assign reqBytes = (reqSize == `AIOX_SIZE_BYTE) ? `AIOX_BYTES_1 :
                    (reqSize == `AIOX_SIZE_WORD) ? `AIOX_BYTES_2 : `AIOX_BYTES_4;

  // The acknowledge chosen sets the width; a word ack on one byte left moves one
  assign stepBytes = (wordAck && (remBytes_q != `AIOX_BYTES_1)) ? `AIOX_BYTES_2 :
                     `AIOX_BYTES_1;

  // Interrupt levels follow the synchronised inputs
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqLevel3_q <= 1'b0;
      irqLevel4_q <= 1'b0;
    end else if (ce) begin
      irqLevel3_q <= ~syncOut[`AIOX_SY_IRQ3];
      irqLevel4_q <= ~syncOut[`AIOX_SY_IRQ4];
    end
  end

  // Main sequencer: one transfer may take several bus cycles
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= {`AIOX_CNT_W{1'b0}};
      remBytes_q <= 3'h0;
      curAddr_q <= 32'h00000000;
      wrBuf_q <= 32'h00000000;
      rdBuf_q <= 32'h00000000;
      errSeen_q <= 1'b0;
      narrowSeen_q <= 1'b0;
      reqReady_q <= 1'b1;
      rspValid_q <= 1'b0;
      rspBusErr_q <= 1'b0;
      rspFault_q <= 1'b0;
      rspWordAck_q <= 1'b0;
      rspRdData_q <= 32'h00000000;
      portAddr_q <= {`AIOX_ADDR_LINES{1'b0}};
      addrSpare_q <= 2'h0;
      rdWr_q <= 1'b1;
      selN_q <= 1'b1;
      dataOut_q <= 16'h0000;
      dataOe_q <= 1'b0;
    end else if (ce) begin
      // Answer strobe lasts one cycle
      rspValid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (reqValid) begin
            if (!inWindow || !aligned || narrow) begin
              // Refused: answer at once, no select is driven
              rspValid_q <= 1'b1;
              rspFault_q <= 1'b1;
              rspBusErr_q <= 1'b0;
              rspRdData_q <= 32'h00000000;
            end else begin
              // Drive address, direction and write data ahead of select
              reqReady_q <= 1'b0;
              remBytes_q <= reqBytes;
              curAddr_q <= reqAddr;
              portAddr_q <= reqAddr[`AIOX_ADDR_LINES-1:0];
              addrSpare_q <= reqAddr[`AIOX_WIN_LSB-1:`AIOX_SPARE_LSB];
              rdWr_q <= ~reqWrite;
              // Left-justify so the first byte sits on the top lanes
              wrBuf_q <= (reqSize == `AIOX_SIZE_BYTE) ? {reqWrData[7:0], 24'h000000} :
                         (reqSize == `AIOX_SIZE_WORD) ? {reqWrData[15:0], 16'h0000} :
                         reqWrData;
              dataOut_q <= (reqSize == `AIOX_SIZE_BYTE) ? {reqWrData[7:0], 8'h00} :
                           (reqSize == `AIOX_SIZE_WORD) ? reqWrData[15:0] :
                           reqWrData[31:16];
              dataOe_q <= reqWrite;
              rdBuf_q <= 32'h00000000;
              errSeen_q <= 1'b0;
              narrowSeen_q <= 1'b0;
              cnt_q <= CNT_ONE;
              state_q <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          // Lead time covers both address and write data setup
          if (cnt_q >= SETUP_CYC) begin
            selN_q <= 1'b0;
            cnt_q <= CNT_ONE;
            state_q <= ST_SEL;
          end else begin
            cnt_q <= cnt_q + CNT_ONE;
          end
        end
        ST_SEL: begin
          if (anyAck) begin
            // Width taken from the acknowledge line seen
            rspWordAck_q <= wordAck;
            if (wordAck && (remBytes_q == `AIOX_BYTES_1)) begin
              narrowSeen_q <= 1'b1;
            end
            cnt_q <= CNT_ONE;
            state_q <= ST_HOLD;
          end else if (cnt_q >= tmoCyc) begin
            // No acknowledge in time: abort the whole transfer
            errSeen_q <= 1'b1;
            remBytes_q <= 3'h0;
            selN_q <= 1'b1;
            cnt_q <= CNT_ONE;
            state_q <= ST_AHOLD;
          end else begin
            cnt_q <= cnt_q + CNT_ONE;
          end
        end
        ST_HOLD: begin
          // Select and write data held; read data settles meanwhile
          if (cnt_q >= HOLD_CYC) begin
            if (stepBytes == `AIOX_BYTES_2) begin
              rdBuf_q <= {rdBuf_q[15:0], dataIn};
              wrBuf_q <= {wrBuf_q[15:0], 16'h0000};
            end else begin
              rdBuf_q <= {rdBuf_q[23:0], dataIn[15:8]};
              wrBuf_q <= {wrBuf_q[23:0], 8'h00};
            end
            remBytes_q <= remBytes_q - stepBytes;
            curAddr_q <= curAddr_q + {29'h00000000, stepBytes};
            selN_q <= 1'b1;
            cnt_q <= CNT_ONE;
            state_q <= ST_AHOLD;
          end else begin
            cnt_q <= cnt_q + CNT_ONE;
          end
        end
        ST_AHOLD: begin
          // Address, direction and data stay put after select rises
          if (cnt_q >= AHOLD_CYC) begin
            dataOe_q <= 1'b0;
            cnt_q <= CNT_ONE;
            state_q <= ST_GAP;
          end else begin
            cnt_q <= cnt_q + CNT_ONE;
          end
        end
        ST_GAP: begin
          // Next cycle waits for the gap and for both acks to be released
          if ((cnt_q >= GAP_CYC) && !anyAck) begin
            if (remBytes_q != 3'h0) begin
              // Next piece of a split transfer
              portAddr_q <= curAddr_q[`AIOX_ADDR_LINES-1:0];
              addrSpare_q <= curAddr_q[`AIOX_WIN_LSB-1:`AIOX_SPARE_LSB];
              dataOut_q <= wrBuf_q[31:16];
              dataOe_q <= ~rdWr_q;
              cnt_q <= CNT_ONE;
              state_q <= ST_SETUP;
            end else begin
              // Transfer complete: answer and return to idle
              rspValid_q <= 1'b1;
              rspBusErr_q <= errSeen_q;
              rspFault_q <= narrowSeen_q;
              rspRdData_q <= errSeen_q ? 32'h00000000 : rdBuf_q;
              reqReady_q <= 1'b1;
              rdWr_q <= 1'b1;
              state_q <= ST_IDLE;
            end
          end else if (cnt_q < GAP_CYC) begin
            cnt_q <= cnt_q + CNT_ONE;
          end
        end
        default: begin
          // Unknown code: drop back to a safe idle
          selN_q <= 1'b1;
          dataOe_q <= 1'b0;
          reqReady_q <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // aiox_port

// ==== hw/aiox_port_defs.vh ====
// Constants for the asynchronous I/O expansion port host controller
`ifndef AIOX_PORT_DEFS_VH
`define AIOX_PORT_DEFS_VH

// System clock period in ns (100 MHz)
`define AIOX_CLK_NS 10

// Bus error timeout, older and later boards, in ns
`define AIOX_TMO_OLD_NS 61000
`define AIOX_TMO_NEW_NS 125000
// Longest times rounded down to whole 10 ns cycles, sized to the counter
`define AIOX_TMO_OLD_CYC 14'h17D4
`define AIOX_TMO_NEW_CYC 14'h30D4

// Least times in ns, taken at the slowest listed processor clock
`define AIOX_ADDR_LEAD_NS 100
`define AIOX_DATA_LEAD_NS 20
`define AIOX_SEL_HOLD_NS 110
`define AIOX_ADDR_HOLD_NS 20
`define AIOX_GAP_NS 100
// Least times rounded up to whole 10 ns cycles, sized so nothing is cut silently
`define AIOX_ADDR_LEAD_CYC 14'h000A
`define AIOX_DATA_LEAD_CYC 14'h0002
`define AIOX_SEL_HOLD_CYC 14'h000B
`define AIOX_ADDR_HOLD_CYC 14'h0002
`define AIOX_GAP_CYC 14'h000A

// Counter width, large enough for the longest timeout
`define AIOX_CNT_W 14

// Window decode: 4096-byte window, ten driven lines plus two spares
`define AIOX_WIN_LSB 12
`define AIOX_ADDR_LINES 10
`define AIOX_SPARE_LSB 10
`define AIOX_WIN_BASE 32'h00000000

// Transfer size codes on the request port
`define AIOX_SIZE_BYTE 2'h0
`define AIOX_SIZE_WORD 2'h1
`define AIOX_SIZE_LONG 2'h2

// Byte counts of a transfer
`define AIOX_BYTES_1 3'h1
`define AIOX_BYTES_2 3'h2
`define AIOX_BYTES_4 3'h4

// Synchroniser bit positions
`define AIOX_SY_BACK 0
`define AIOX_SY_WACK 1
`define AIOX_SY_IRQ3 2
`define AIOX_SY_IRQ4 3
`define AIOX_SY_W 4

`endif

// ==== hw/aiox_sync.v ====
// Two-flop level synchroniser with clock enable
`timescale 1ns/1ps
module aiox_sync #(
  parameter W = 1,
  parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst_n,
  input wire ce,
  // Asynchronous levels in, synchronised levels out
  input wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);

  reg [W-1:0] meta_q; // First stage, read only by the second stage
  reg [W-1:0] sync_q; // Second stage, safe to use

  // Two stages give the first flop a full cycle to settle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else if (ce) begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;

endmodule // aiox_sync

// ==== verification/aiox_periph_model.sv ====
// Behavioural peripheral board at the far side of the expansion port
`timescale 1ns/1ps
module aiox_periph_model (
  // Port pins from the host
  input wire sys_clk,
  input wire selN,
  input wire rdWr,
  input wire [11:0] addr,
  input wire [15:0] dataOut,
  // Behaviour controls
  input wire wordDev,
  input wire noAck,
  input wire [3:0] dly,
  input wire doReset,
  // Answers to the host
  output logic byteAckN,
  output logic wordAckN,
  output logic [15:0] dataIn,
  // Shared reset line as the board drives it
  output logic rstDrvN
);
  logic [11:0] logA [0:7]; // Address of every cycle, ring of eight
  logic [15:0] logD [0:7]; // Write data seen on D31..D16
  int nLog = 0;
  int nSel = 0;
  int lowCyc = 0; // Select low time of the last cycle
  time tFall;
  // Pull-ups hold both acks high while released
  initial begin
    byteAckN = 1'b1;
    wordAckN = 1'b1;
    dataIn = 16'h0000;
    rstDrvN = 1'b1;
  end
  // Board-driven reset pulse, long enough for the processor to see it
  always begin
    @(posedge doReset);
    @(posedge sys_clk);
    #3;
    rstDrvN = 1'b0;
    repeat (520) @(posedge sys_clk);
    #3;
    rstDrvN = 1'b1;
  end
  // One bus cycle per select fall; dly sets a prompt or slow board
  always begin
    @(negedge selN);
    tFall = $time;
    nSel++;
    repeat (dly) @(posedge sys_clk);
    #3;
    logA[nLog % 8] = addr;
    logD[nLog % 8] = dataOut;
    nLog++;
    // Read value carries its address so a lane slip shows
    if (rdWr) begin
      dataIn = {addr[7:0] ^ 8'h5A, ~addr[7:0]};
    end
    // The width of the board picks the ack line
    if (!noAck) begin
      byteAckN = wordDev;
      wordAckN = !wordDev;
    end
    @(posedge selN);
    lowCyc = ($time - tFall) / 10;
    #2;
    // Released lines must not keep the old value
    byteAckN = 1'b1;
    wordAckN = 1'b1;
    dataIn = ~dataIn;
  end
endmodule // aiox_periph_model

// ==== verification/aiox_port_asserts.sv ====
// Concurrent checks on the expansion port host pins
`timescale 1ns/1ps
module aiox_port_asserts #(
  parameter [13:0] TMO_OLD_CYC = 14'h17D4,
  parameter [13:0] TMO_NEW_CYC = 14'h30D4
) (
  // Clock, reset, configuration
  input wire sys_clk,
  input wire rst_n,
  input wire cfgLateBoard,
  input wire cfgWordDevice,
  // Request and answer
  input wire reqValid,
  input wire [31:0] reqAddr,
  input wire [1:0] reqSize,
  input wire reqReady_q,
  input wire rspValid_q,
  input wire rspFault_q,
  // Port pins
  input wire [9:0] portAddr_q,
  input wire rdWr_q,
  input wire selN_q,
  input wire byte_ack_n,
  input wire word_ack_n,
  input wire [15:0] dataOut_q,
  input wire dataOe_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  reg [13:0] lowCnt_q; // Cycles select has been low
  // Counter restarts whenever select is high
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) lowCnt_q <= 14'h0000;
    else if (selN_q) lowCnt_q <= 14'h0000;
    else lowCnt_q <= lowCnt_q + 14'h0001;
  end
  win_refuse_a: assert property (reqValid && reqReady_q && (reqAddr[31:12] != 20'h00000 ||
    (reqSize == 2'h1 && reqAddr[0]) || (reqSize == 2'h2 && reqAddr[1:0] != 2'h0) ||
    (reqSize == 2'h0 && cfgWordDevice)) |=> rspValid_q && rspFault_q && selN_q) else $error("bad refusal");
  idle_sel_a: assert property (reqReady_q |-> selN_q) else $error("select while idle");
  rw_stable_a: assert property (!selN_q && !$past(selN_q) |->
    $stable(rdWr_q) && $stable(portAddr_q)) else $error("address moved under select");
  wr_lead_a: assert property ($fell(selN_q) && !rdWr_q |->
    $past(dataOe_q, 2) && $stable(dataOut_q)) else $error("write data late");
  wr_hold_a: assert property (!selN_q && !rdWr_q |-> dataOe_q) else $error("write data dropped");
  rd_float_a: assert property (!selN_q && rdWr_q |-> !dataOe_q) else $error("drive on read");
  ack_hold_a: assert property ($fell(byte_ack_n && word_ack_n) && !selN_q |->
    !selN_q [*8]) else $error("select hold short");
  tmo_bound_a: assert property (lowCnt_q <= (cfgLateBoard ? TMO_NEW_CYC : TMO_OLD_CYC))
    else $error("timeout overrun");
  cyc_gap_a: assert property ($rose(selN_q) |-> selN_q [*8]) else $error("gap short");
endmodule // aiox_port_asserts
bind aiox_port aiox_port_asserts #(.TMO_OLD_CYC(TMO_OLD_CYC), .TMO_NEW_CYC(TMO_NEW_CYC)) chk (
  .sys_clk, .rst_n, .cfgLateBoard, .cfgWordDevice, .reqValid, .reqAddr, .reqSize, .reqReady_q,
  .rspValid_q, .rspFault_q, .portAddr_q, .rdWr_q, .selN_q, .byte_ack_n, .word_ack_n, .dataOut_q,
  .dataOe_q);

// ==== verification/aiox_port_tb.sv ====
// Self-checking bench for the expansion port host
`timescale 1ns/1ps
module aiox_port_tb;
  // Stimulus, all driven 1 ns after the rising edge
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfgLateBoard = 1'b0;
  logic cfgWordDevice = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [31:0] reqAddr = 32'h00000000;
  logic [1:0] reqSize = 2'h0;
  logic [31:0] reqWrData = 32'h00000000;
  logic irq3N = 1'b1;
  logic irq4N = 1'b1;
  logic noAck = 1'b0;
  logic [3:0] dly = 4'h3;
  logic doReset = 1'b0; // Asks the board to pull the shared reset
  // Design outputs and board answers
  wire reqReady_q, rspValid_q, rspBusErr_q, rspFault_q, rspWordAck_q, rdWr_q, selN_q;
  wire dataOe_q, irqLevel3_q, irqLevel4_q, byteAckN, wordAckN;
  wire [31:0] rspRdData_q;
  wire [9:0] portAddr_q;
  wire [1:0] addrSpare_q;
  wire [15:0] dataIn, dataOut_q;
  wire rstDrvN; // Shared reset as the board drives it
  wire sysRstN = rst_n & rstDrvN; // Bench and board pull one reset line
  int mismatches = 0;
  int num_checks = 0;
  int lat; // Cycles from take to answer
  always #5 sys_clk = ~sys_clk;
  // Short timeouts keep the run brief: 40 and 60 cycles
  aiox_port #(.TMO_OLD_CYC(14'h0028), .TMO_NEW_CYC(14'h003C)) DUT (.sys_clk, .rst_n(sysRstN),
    .ce(1'b1),
    .cfgLateBoard, .cfgWordDevice, .reqValid, .reqWrite, .reqAddr, .reqSize, .reqWrData,
    .reqReady_q, .rspValid_q, .rspBusErr_q, .rspFault_q, .rspWordAck_q, .rspRdData_q,
    .portAddr_q, .addrSpare_q, .rdWr_q, .selN_q, .byte_ack_n(byteAckN), .word_ack_n(wordAckN),
    .dataIn, .dataOut_q, .dataOe_q, .irq3N, .irq4N, .irqLevel3_q, .irqLevel4_q);
  aiox_periph_model P (.sys_clk, .selN(selN_q), .rdWr(rdWr_q), .addr({addrSpare_q, portAddr_q}),
    .dataOut(dataOut_q), .wordDev(cfgWordDevice), .noAck, .dly, .doReset, .byteAckN, .wordAckN,
    .dataIn, .rstDrvN);
  // Single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One request, held for a single clock edge, then a bounded wait for the answer
  task automatic xfer(input logic w, input logic [31:0] a, input logic [1:0] s,
      input logic [31:0] d);
    // Let an edge pass so the strobe is never lowered and raised in one step
    @(posedge sys_clk);
    #1;
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqSize = s;
    reqWrData = d;
    @(posedge sys_clk);
    #1;
    reqValid = 1'b0;
    lat = 0;
    while (rspValid_q !== 1'b1 && lat < 4000) begin
      @(posedge sys_clk);
      #1;
      lat++;
    end
    if (lat == 4000) begin
      mismatches++;
      end_sim();
    end
  endtask
  // Outside window, misaligned word and long, byte to a word board
  task automatic t_refuse();
    logic [31:0] ad [4] = '{32'h00001000, 32'h00000001, 32'h00000002, 32'h00000000};
    logic [1:0] sz [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    int n0;
    for (int i = 0; i < 4; i++) begin
      n0 = P.nSel;
      cfgWordDevice = (i == 3);
      xfer(1'b0, ad[i], sz[i], 32'h00000000);
      check(rspFault_q, 1'b1);
      check(lat, 0);
      check(P.nSel, n0);
    end
    $display("refusal test done");
  endtask
  // Byte read using the spare address lines
  task automatic t_rd_byte();
    cfgWordDevice = 1'b0;
    xfer(1'b0, 32'h00000C37, 2'h0, 32'h00000000);
    check(rspRdData_q, 32'h0000006D);
    check(rspWordAck_q, 1'b0);
    check(P.logA[(P.nLog - 1) % 8], 12'hC37);
    $display("byte read test done");
  endtask
  // Long write to a byte board: four pieces, top byte first
  task automatic t_wr_long();
    int b;
    logic [31:0] d;
    b = P.nLog;
    d = 32'h1234ABCD;
    xfer(1'b1, 32'h00000104, 2'h2, d);
    check(P.nLog - b, 4);
    for (int i = 0; i < 4; i++) begin
      check(P.logA[(b + i) % 8], 12'h104 + i);
      check(P.logD[(b + i) % 8][15:8], d[31 - 8 * i -: 8]);
    end
    check(rspFault_q, 1'b0);
    $display("long write test done");
  endtask
  // Slow word board: long read in two pieces, then word write back to back
  task automatic t_word_dev();
    cfgWordDevice = 1'b1;
    dly = 4'h9;
    xfer(1'b0, 32'h00000208, 2'h2, 32'h00000000);
    check(rspRdData_q, 32'h52F750F5);
    check(rspWordAck_q, 1'b1);
    xfer(1'b1, 32'h0000020C, 2'h1, 32'h0000BEEF);
    check(P.logD[(P.nLog - 1) % 8], 16'hBEEF);
    dly = 4'h3;
    $display("word board test done");
  endtask
  // Board never answers, both timeout settings
  task automatic t_timeout();
    noAck = 1'b1;
    for (int late = 0; late < 2; late++) begin
      cfgLateBoard = late;
      xfer(1'b0, 32'h00000010, 2'h1, 32'h00000000);
      check(rspBusErr_q, 1'b1);
      check(rspRdData_q, 32'h00000000);
      check(P.lowCyc, late ? 60 : 40);
    end
    noAck = 1'b0;
    $display("timeout test done");
  endtask
  // Board pulls the shared reset mid-cycle; host drops select and recovers
  task automatic t_board_reset();
    int n;
    @(posedge sys_clk);
    #1;
    noAck = 1'b1;
    reqValid = 1'b1;
    reqWrite = 1'b0;
    reqAddr = 32'h00000020;
    reqSize = 2'h1;
    @(posedge sys_clk);
    #1;
    reqValid = 1'b0;
    n = 0;
    while (selN_q !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 40) begin
      mismatches++;
      end_sim();
    end
    // Give the board time to reach its wait for deselect
    repeat (6) @(posedge sys_clk);
    #1;
    check(selN_q, 1'b0);
    doReset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check(selN_q, 1'b1);
    check(rdWr_q, 1'b1);
    check(dataOe_q, 1'b0);
    n = 0;
    while (sysRstN !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 1000) begin
      mismatches++;
      end_sim();
    end
    check(n, 520);
    check(reqReady_q, 1'b1);
    check(rspValid_q, 1'b0);
    doReset = 1'b0;
    noAck = 1'b0;
    xfer(1'b0, 32'h00000020, 2'h1, 32'h00000000);
    check(rspRdData_q, 32'h00007ADF);
    check(rspBusErr_q, 1'b0);
    $display("board reset test done");
  endtask
  // Interrupt inputs reach their own levels
  task automatic t_irq();
    irq3N = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check(irqLevel3_q, 1'b1);
    check(irqLevel4_q, 1'b0);
    irq4N = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check(irqLevel4_q, 1'b1);
    irq3N = 1'b1;
    irq4N = 1'b1;
    $display("interrupt test done");
  endtask
  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_refuse();
    t_rd_byte();
    t_wr_long();
    t_word_dev();
    t_timeout();
    t_board_reset();
    t_irq();
    end_sim();
  end
endmodule // aiox_port_tb
